// File: hw/adc_ctl_defs.svh
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH

// Register byte offsets on the AXI4-Lite port.
`define OFF_CTRL 8'h00
`define OFF_STEP 8'h04
`define OFF_STATUS 8'h08
`define OFF_CONFIG 8'h0C

// Control register fields.
`define CTRL_LINK_EN 0

// Status register fields.
`define ST_RESULT_LO 0
`define ST_BUSY 8
`define ST_EXT_MODE 9
`define ST_POWER_DOWN 10
`define ST_REF_OFF 11
`define ST_RESULT_VALID 12

// Reset values.
`define CTRL_RESET 1'b1
`define STEP_RESET 8'h10
`define RESULT_RESET 8'h00

// Control byte fields.
`define CB_START 7
`define CB_SEL_HI 6
`define CB_SEL_LO 4
`define CB_UNI 3
`define CB_SGL 2
`define CB_PWR 1
`define CB_EXT 0

// Serial timing counts, in shift clock edges.
`define TRACK_BITS 4'h6
`define CTRL_BITS 4'h8
`define SAR_STEPS 4'h8
`define STROBE_RISE_FALL 4'h8
`define MSB_FALL 4'hA
`define RESULT_BITS 4'h8

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/adc_ctl_pkg.sv
package adc_ctl_pkg;

  typedef enum logic [5:0] {
    ST_HUNT = 6'h01,
    ST_CTRL = 6'h02,
    ST_CONV_EXT = 6'h04,
    ST_CONV_INT = 6'h08,
    ST_READY = 6'h10,
    ST_SHIFT = 6'h20
  } state_t;

  typedef struct packed {
    logic [5:0] stage1;
    logic [5:0] stage2;
    logic prevClock;
  } sync_t;

  typedef struct packed {
    state_t state;
    logic [7:0] shift;
    logic [3:0] bitCount;
    logic [3:0] edgeCount;
    logic [7:0] divCount;
    logic [7:0] sar;
    logic [2:0] sarIdx;
    logic [3:0] stepCount;
    logic [7:0] result;
    logic resultValid;
    logic [7:0] ctrlByte;
    logic extMode;
    logic unipolar;
    logic softDown;
    logic trackHold;
    logic [7:0] posSel;
    logic [7:0] negSel;
    logic negCommon;
    logic strobe;
    logic serialOut;
    logic linkEnable;
    logic [7:0] stepCycles;
    logic awPend;
    logic [7:0] awAddr;
    logic wPend;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } core_t;

endpackage

// File: hw/link_sync_if.sv
`timescale 1ns/100ps
interface link_sync_if;
  logic clockRise;
  logic clockFall;
  logic selectN;
  logic dataIn;
  logic compareHigh;
  logic levelLow;
  logic levelHigh;

  modport source (
    output clockRise,
    output clockFall,
    output selectN,
    output dataIn,
    output compareHigh,
    output levelLow,
    output levelHigh
  );

  modport sink (
    input clockRise,
    input clockFall,
    input selectN,
    input dataIn,
    input compareHigh,
    input levelLow,
    input levelHigh
  );
endinterface

// File: hw/link_sync.sv
`timescale 1ns/100ps
module link_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic shiftClock,
  input wire logic selectN,
  input wire logic serialIn,
  input wire logic comparatorHigh,
  input wire logic shutdownLevelLow,
  input wire logic shutdownLevelHigh,
  link_sync_if.source link
);
  adc_ctl_pkg::sync_t cur;
  adc_ctl_pkg::sync_t next_cur;
  logic shiftClockSync;

  assign shiftClockSync = cur.stage2[5];

  // Edges are found only on the second stage so that a metastable first stage never reaches logic.
  always_comb
  begin
    next_cur = cur;
    next_cur.stage1 = {shiftClock, shutdownLevelHigh, shutdownLevelLow, comparatorHigh, serialIn, selectN};
    next_cur.stage2 = cur.stage1;
    next_cur.prevClock = shiftClockSync;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cur <= '{stage1: 6'h01, stage2: 6'h01, prevClock: 1'b0};
    else
      cur <= next_cur;
  end
  assign link.clockRise = shiftClockSync & ~cur.prevClock;
  assign link.clockFall = ~shiftClockSync & cur.prevClock;
  assign link.selectN = cur.stage2[0];
  assign link.dataIn = cur.stage2[1];
  assign link.compareHigh = cur.stage2[2];
  assign link.levelLow = cur.stage2[3];
  assign link.levelHigh = cur.stage2[4];
endmodule // link_sync

// File: hw/serial_adc_control.sv
`timescale 1ns/100ps
`include "adc_ctl_defs.svh"
// Contract
// (RL1) Output changes on falling edges, floats deselected.
// (RL2) Input sampled on shift clock rising edge.
// (RL3) No bits taken while select is high.
// (RL4) Internal mode strobe low during conversion.
// (RL5) External mode strobe high two periods before MSB.
// (RL6) External mode strobe floats when deselected.
// (RL7) External mode steps conversion on shift clock.
// (RL8) Host keeps clock high time 45 to 55%.
// (RL9) Shutdown level: low off, high reference off.
// (RL10) Track starts falling edge after sixth bit.
// (RL11) Hold starts falling edge after eighth bit.
// (RL12) Acquisition window spans exactly two clock cycles.
// (RL13) Single-ended: selected input positive, negative common.
// (RL14) Differential pairs only 0/1, 2/3, 4/5, 6/7.
// (RL15) Single-ended channel code decode to input.
// (RL16) Differential code decode, high bit odd positive.
// (RL17) Eight-bit approximation result shifted out serially.
// (RL18) Control byte field layout start to clock.
// (RL19) Clock select bit one picks external mode.
// (RL20) Leading zeros dropped, first one is start.
// (RL21) External conversion takes ten shift clock cycles.
// (RL22) Internal conversion paced by programmable divider.
// (RL23) Result MSB first after strobe pulse ends.
module serial_adc_control (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic shiftClock,
  input wire logic selectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  output logic conversionStrobe,
  output logic conversionStrobeEn,
  input wire logic shutdownLevelLow,
  input wire logic shutdownLevelHigh,
  input wire logic comparatorHigh,
  output logic [7:0] dacCode,
  output logic trackHold,
  output logic [7:0] posInput,
  output logic [7:0] negInput,
  output logic commonReturn,
  output logic unipolarMode,
  output logic powerDown,
  output logic referenceOff
);
  adc_ctl_pkg::core_t cur;
  adc_ctl_pkg::core_t next_cur;
  link_sync_if link ();

  link_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .shiftClock(shiftClock),
    .selectN(selectN),
    .serialIn(serialIn),
    .comparatorHigh(comparatorHigh),
    .shutdownLevelLow(shutdownLevelLow),
    .shutdownLevelHigh(shutdownLevelHigh),
    .link(link.source)
  );

  // One approximation step: keep or drop the trial bit, then try the next lower one.
  function automatic logic [7:0] sarStep(input logic [7:0] code, input logic [2:0] idx, input logic above);
    logic [7:0] c;
    c = code;
    c[idx] = above;
    if (idx != 3'h0)
      c[idx - 3'h1] = 1'b1;
    return c;
  endfunction

  // Both modes share one routing: the positive index is {channel_sel_1, channel_sel_0, channel_sel_2}; the
  // differential partner differs only in the lowest index bit.
  function automatic logic [16:0] routeDecode(input logic [2:0] sel, input logic single);
    logic [2:0] posIdx;
    logic [16:0] r;
    posIdx = {sel[1], sel[0], sel[2]};
    r = 17'h00000;
    r[posIdx] = 1'b1;
    if (single)
      r[16] = 1'b1;
    else
      r[{posIdx[2:1], ~posIdx[0]} + 4'h8] = 1'b1;
    return r;
  endfunction

  function automatic logic [31:0] regRead(input adc_ctl_pkg::core_t c, input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h00000000;
    case (addr)
      `OFF_CTRL: v[`CTRL_LINK_EN] = c.linkEnable;
      `OFF_STEP: v[7:0] = c.stepCycles;
      `OFF_STATUS:
      begin
        v[`ST_RESULT_LO +: 8] = c.result;
        v[`ST_BUSY] = (c.state == adc_ctl_pkg::ST_CONV_EXT) || (c.state == adc_ctl_pkg::ST_CONV_INT);
        v[`ST_EXT_MODE] = c.extMode;
        v[`ST_POWER_DOWN] = c.softDown | link.levelLow;
        v[`ST_REF_OFF] = link.levelHigh;
        v[`ST_RESULT_VALID] = c.resultValid;
      end
      `OFF_CONFIG: v[7:0] = c.ctrlByte;
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr == `OFF_CTRL) || (addr == `OFF_STEP) || (addr == `OFF_STATUS) || (addr == `OFF_CONFIG);
  endfunction

  always_comb
  begin
    logic [16:0] route;
    logic [3:0] count;
    route = 17'h00000;
    count = 4'h0;
    next_cur = cur;

    // Register bus: address and data are taken independently, answered together.
    if (awvalid && awready)
    begin
      next_cur.awPend = 1'b1;
      next_cur.awAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_cur.wPend = 1'b1;
      next_cur.wData = wdata;
      next_cur.wStrb = wstrb;
    end
    if (cur.awPend && cur.wPend && !cur.bValid)
    begin
      next_cur.awPend = 1'b0;
      next_cur.wPend = 1'b0;
      next_cur.bValid = 1'b1;
      next_cur.bResp = mapped(cur.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (cur.wStrb[0] && cur.awAddr == `OFF_CTRL)
        next_cur.linkEnable = cur.wData[`CTRL_LINK_EN];
      if (cur.wStrb[0] && cur.awAddr == `OFF_STEP)
        next_cur.stepCycles = cur.wData[7:0];
    end
    if (cur.bValid && bready)
      next_cur.bValid = 1'b0;
    if (arvalid && arready)
    begin
      next_cur.rValid = 1'b1;
      next_cur.rData = regRead(cur, araddr);
      next_cur.rResp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (cur.rValid && rready)
      next_cur.rValid = 1'b0;

    case (cur.state)
      adc_ctl_pkg::ST_HUNT:
      begin
        next_cur.serialOut = 1'b0;
        // (RL20) Skip leading zeros
        // (RL3) Selected only
        if (!link.selectN && link.clockRise && link.dataIn && cur.linkEnable)
        begin
          next_cur.shift = 8'h01;
          next_cur.bitCount = 4'h1;
          next_cur.softDown = 1'b0;
          next_cur.state = adc_ctl_pkg::ST_CTRL;
        end
      end
      adc_ctl_pkg::ST_CTRL:
      begin
        if (link.selectN)
        begin
          next_cur.trackHold = 1'b0;
          next_cur.state = adc_ctl_pkg::ST_HUNT;
        end
        // (RL2) Sample on rise
        else if (link.clockRise && cur.bitCount < `CTRL_BITS)
        begin
          next_cur.shift = {cur.shift[6:0], link.dataIn};
          next_cur.bitCount = cur.bitCount + 4'h1;
        end
        // (RL10) Start tracking
        // (RL12) Two-cycle window
        else if (link.clockFall && cur.bitCount == `TRACK_BITS)
        begin
          next_cur.trackHold = 1'b1;
          route = routeDecode(cur.shift[4:2], cur.shift[0]);
          // (RL13) Negative to common
          // (RL14) Pairs only
          // (RL15) Single-ended decode
          // (RL16) Differential decode
          next_cur.posSel = route[7:0];
          next_cur.negSel = route[15:8];
          next_cur.negCommon = route[16];
          next_cur.unipolar = cur.shift[1];
        end
        // (RL11) Enter hold
        else if (link.clockFall && cur.bitCount == `CTRL_BITS)
        begin
          next_cur.trackHold = 1'b0;
          // (RL18) Byte fields
          next_cur.ctrlByte = cur.shift;
          next_cur.extMode = cur.shift[`CB_EXT];
          next_cur.sar = 8'h80;
          next_cur.sarIdx = 3'h7;
          next_cur.stepCount = 4'h0;
          next_cur.edgeCount = 4'h0;
          next_cur.divCount = 8'h00;
          // (RL19) Mode select
          if (cur.shift[`CB_EXT])
          begin
            next_cur.strobe = 1'b0;
            next_cur.state = adc_ctl_pkg::ST_CONV_EXT;
          end
          else
          begin
            // (RL4) Strobe low
            next_cur.strobe = 1'b0;
            next_cur.state = adc_ctl_pkg::ST_CONV_INT;
          end
        end
      end
      adc_ctl_pkg::ST_CONV_EXT:
      begin
        // Deselecting mid-conversion abandons it; the previous result stays readable.
        if (link.selectN)
        begin
          next_cur.strobe = 1'b0;
          next_cur.state = adc_ctl_pkg::ST_HUNT;
        end
        else if (link.clockFall)
        begin
          count = cur.edgeCount + 4'h1;
          next_cur.edgeCount = count;
          // (RL7) Step on shift clock
          if (count <= `SAR_STEPS)
          begin
            next_cur.sar = sarStep(cur.sar, cur.sarIdx, link.compareHigh);
            next_cur.sarIdx = cur.sarIdx - 3'h1;
          end
          // (RL5) Two-period strobe
          if (count == `STROBE_RISE_FALL)
            next_cur.strobe = 1'b1;
          // (RL21) Ten cycles total
          if (count == `MSB_FALL)
          begin
            next_cur.strobe = 1'b0;
            next_cur.result = cur.sar;
            next_cur.resultValid = 1'b1;
            next_cur.softDown = ~cur.ctrlByte[`CB_PWR];
            // (RL23) MSB first
            next_cur.serialOut = cur.sar[7];
            next_cur.edgeCount = 4'h1;
            next_cur.state = adc_ctl_pkg::ST_SHIFT;
          end
        end
      end
      adc_ctl_pkg::ST_CONV_INT:
      begin
        // (RL22) Divider paced steps
        if (cur.divCount + 8'h01 >= cur.stepCycles)
        begin
          next_cur.divCount = 8'h00;
          next_cur.sar = sarStep(cur.sar, cur.sarIdx, link.compareHigh);
          next_cur.sarIdx = cur.sarIdx - 3'h1;
          next_cur.stepCount = cur.stepCount + 4'h1;
          if (cur.stepCount + 4'h1 == `SAR_STEPS)
          begin
            // (RL4) Strobe high at end
            next_cur.strobe = 1'b1;
            next_cur.result = sarStep(cur.sar, cur.sarIdx, link.compareHigh);
            next_cur.resultValid = 1'b1;
            next_cur.softDown = ~cur.ctrlByte[`CB_PWR];
            next_cur.state = adc_ctl_pkg::ST_READY;
          end
        end
        else
          next_cur.divCount = cur.divCount + 8'h01;
      end
      adc_ctl_pkg::ST_READY:
      begin
        // (RL23) First bit after strobe
        if (!link.selectN && link.clockFall)
        begin
          next_cur.serialOut = cur.result[7];
          next_cur.edgeCount = 4'h1;
          next_cur.state = adc_ctl_pkg::ST_SHIFT;
        end
      end
      adc_ctl_pkg::ST_SHIFT:
      begin
        if (link.selectN)
          next_cur.state = adc_ctl_pkg::ST_HUNT;
        // (RL1) Falling-edge update
        // (RL17) Serial result out
        else if (link.clockFall)
        begin
          if (cur.edgeCount == `RESULT_BITS)
          begin
            next_cur.serialOut = 1'b0;
            next_cur.state = adc_ctl_pkg::ST_HUNT;
          end
          else
          begin
            next_cur.serialOut = cur.result[3'(`RESULT_BITS - 4'h1 - cur.edgeCount)];
            next_cur.edgeCount = cur.edgeCount + 4'h1;
          end
        end
      end
      default: next_cur.state = adc_ctl_pkg::ST_HUNT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.state <= adc_ctl_pkg::ST_HUNT;
      cur.result <= `RESULT_RESET;
      cur.strobe <= 1'b1;
      cur.linkEnable <= `CTRL_RESET;
      cur.stepCycles <= `STEP_RESET;
    end
    else
      cur <= next_cur;
  end

  assign awready = ~cur.awPend & ~cur.bValid;
  assign wready = ~cur.wPend & ~cur.bValid;
  assign bvalid = cur.bValid;
  assign bresp = cur.bResp;
  assign arready = ~cur.rValid;
  assign rvalid = cur.rValid;
  assign rdata = cur.rData;
  assign rresp = cur.rResp;

  // (RL1) Float when deselected
  assign serialOut = cur.serialOut;
  assign serialOutEn = ~link.selectN;
  // (RL6) External-only float
  assign conversionStrobe = cur.strobe;
  assign conversionStrobeEn = ~cur.extMode | ~link.selectN;
  assign dacCode = cur.sar;
  assign trackHold = cur.trackHold;
  assign posInput = cur.posSel;
  assign negInput = cur.negSel;
  assign commonReturn = cur.negCommon;
  assign unipolarMode = cur.unipolar;
  // (RL9) Three-level shutdown
  assign powerDown = cur.softDown | link.levelLow;
  assign referenceOff = link.levelHigh & ~link.levelLow;
endmodule // serial_adc_control

// File: dv/serial_adc_chk.sv
`timescale 1ns/100ps
module serial_adc_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic selectN,
  input wire logic shiftClock,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic conversionStrobe,
  input wire logic shutdownLevelLow,
  input wire logic shutdownLevelHigh,
  input wire logic [7:0] posInput,
  input wire logic [7:0] negInput,
  input wire logic commonReturn,
  input wire logic powerDown,
  input wire logic referenceOff
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence strobeRise;
    $rose(conversionStrobe);
  endsequence
  a_write_answer: assert property (wrTaken |-> ##[1:2] bvalid)
    else $error("write response late");
  a_resp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data unstable");
  a_out_floats: assert property (selectN [*4] |-> !serialOutEn)
    else $error("data out driven while deselected");
  a_out_on_fall: assert property (serialOutEn && !$stable(serialOut) |-> !$past(shiftClock))
    else $error("data out changed off a falling edge");
  // The strobe is high two link periods of eight system clocks each.
  a_strobe_width: assert property (strobeRise |-> conversionStrobe [*8] ##8 conversionStrobe)
    else $error("strobe pulse too short");
  a_level_low: assert property (shutdownLevelLow [*4] |=> powerDown)
    else $error("low level did not shut down");
  a_level_high: assert property ((shutdownLevelHigh && !shutdownLevelLow) [*4] |=> referenceOff && !powerDown)
    else $error("high level decode wrong");
  a_level_float: assert property ((!shutdownLevelHigh) [*4] |=> !referenceOff)
    else $error("reference off without high level");
  a_neg_common: assert property (commonReturn |-> negInput == 8'h00)
    else $error("negative route not common");
  a_pairs_only: assert property (negInput != 8'h00 |-> (posInput | negInput) inside {8'h03, 8'h0C, 8'h30, 8'hC0})
    else $error("illegal differential pair");
  a_pos_onehot: assert property ($onehot0(posInput))
    else $error("several positive inputs");
endmodule // serial_adc_chk

bind serial_adc_control serial_adc_chk serial_adc_chk_inst (.clock, .rst_n, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .selectN, .shiftClock, .serialOut,
  .serialOutEn, .conversionStrobe, .shutdownLevelLow, .shutdownLevelHigh, .posInput, .negInput, .commonReturn,
  .powerDown, .referenceOff);

// File: dv/host_link.sv
`timescale 1ns/100ps
module host_link (
  input wire logic clock,
  input wire logic dataLine,
  input wire logic strobeLine,
  input wire logic trackHold,
  output logic shiftClock,
  output logic selectN,
  output logic serialIn
);
  logic [31:0] rxBits = 32'h0;
  logic [31:0] stbBits = 32'h0;
  logic [31:0] thBits = 32'h0;
  logic idleFill = 1'h0;
  initial
  begin
    shiftClock = 1'h0;
    selectN = 1'h1;
    serialIn = 1'h0;
  end
  // A released data line toggles so that no stale bit can pass for data.
  always @(posedge clock)
  begin
    idleFill <= ~idleFill;
    if (selectN)
      serialIn <= idleFill;
  end
  task automatic selectLink(input logic level);
    @(posedge clock);
    selectN <= level;
  endtask
  task automatic clockBits(input int n, input logic [31:0] tx);
    int i;
    for (i = n - 1; i >= 0; i--)
    begin
      @(posedge clock);
      serialIn <= tx[i];
      repeat (3) @(posedge clock);
      shiftClock <= 1'h1;
      rxBits <= {rxBits[30:0], dataLine};
      stbBits <= {stbBits[30:0], strobeLine};
      thBits <= {thBits[30:0], trackHold};
      repeat (4) @(posedge clock);
      shiftClock <= 1'h0;
    end
  endtask
endmodule // host_link

// File: dv/tb_top.sv
`timescale 1ns/100ps
`include "adc_ctl_defs.svh"
module tb_top;
  logic clock = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, target = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, trackHold, commonReturn, unipolarMode, powerDown, referenceOff;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic shiftClock, selectN, serialIn, serialOut, serialOutEn, conversionStrobe, conversionStrobeEn;
  logic shutdownLevelLow = 1'h0, shutdownLevelHigh = 1'h0, comparatorHigh = 1'h0, idlePat = 1'h0;
  logic [7:0] dacCode, posInput, negInput, ctrl, expPos, expNeg;
  logic dataWire, strobeWire;
  int failCount = 0, nCompared = 0, k, w;

  always #20 clock = ~clock;
  // The comparator says the sampled level is at or above the trial code, so a conversion yields target.
  always @(posedge clock)
  begin
    idlePat <= ~idlePat;
    comparatorHigh <= (target >= dacCode);
  end
  assign dataWire = serialOutEn ? serialOut : idlePat;
  assign strobeWire = conversionStrobeEn ? conversionStrobe : idlePat;

  serial_adc_control serial_adc_control_inst (.clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .shiftClock,
    .selectN, .serialIn, .serialOut, .serialOutEn, .conversionStrobe, .conversionStrobeEn, .shutdownLevelLow,
    .shutdownLevelHigh, .comparatorHigh, .dacCode, .trackHold, .posInput, .negInput, .commonReturn, .unipolarMode,
    .powerDown, .referenceOff);
  host_link host_link_inst (.clock, .dataLine(dataWire), .strobeLine(strobeWire), .trackHold, .shiftClock,
    .selectN, .serialIn);

  task automatic testDone();
    if (failCount == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic giveUp();
    check("wait limit", 32'h1, 32'h0);
    testDone();
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      if (bvalid)
        break;
    end
    bready <= 1'h0;
    rsp = bresp;
    if (n == 64)
      giveUp();
  endtask
  task automatic axiRead(input logic [7:0] a);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clock);
      if (arready)
        arvalid <= 1'h0;
      if (rvalid)
        break;
    end
    rready <= 1'h0;
    rd = rdata;
    rsp = rresp;
    if (n == 64)
      giveUp();
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'h1;
    axiRead(`OFF_CTRL);
    check("ctrl reset", rd, 32'h1);
    axiRead(`OFF_STEP);
    check("step reset", rd, {24'h0, `STEP_RESET});
    axiRead(8'h10);
    check("unmapped read", {rsp, rd[29:0]}, {`RESP_SLVERR, 30'h0});
    axiWrite(8'h10, 32'h5);
    check("unmapped write", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    axiWrite(`OFF_STEP, 32'h8);
    axiRead(`OFF_STEP);
    check("step write", rd, 32'h8);
    // A write without its low byte lane must leave the register alone.
    wstrb <= 4'hE;
    axiWrite(`OFF_STEP, 32'h3);
    wstrb <= 4'hF;
    check("masked write", {30'h0, rsp}, {30'h0, `RESP_OKAY});
    axiRead(`OFF_STEP);
    check("masked step", rd, 32'h8);
    // With the link disabled a full control byte must not reach the routing.
    axiWrite(`OFF_CTRL, 32'h0);
    host_link_inst.selectLink(1'h0);
    host_link_inst.clockBits(8, 32'hFF);
    check("link off", {24'h0, posInput}, 32'h0);
    host_link_inst.selectLink(1'h1);
    axiWrite(`OFF_CTRL, 32'h1);
    shutdownLevelLow <= 1'h1;
    repeat (6) @(posedge clock);
    check("level low", {31'h0, powerDown}, 32'h1);
    shutdownLevelLow <= 1'h0;
    shutdownLevelHigh <= 1'h1;
    repeat (6) @(posedge clock);
    check("level high", {30'h0, referenceOff, powerDown}, 32'h2);
    axiRead(`OFF_STATUS);
    check("status ref off", {31'h0, rd[11]}, 32'h1);
    shutdownLevelHigh <= 1'h0;
    repeat (6) @(posedge clock);
    check("level float", {30'h0, referenceOff, powerDown}, 32'h0);
    // Every channel code in both input modes, external clock, unipolar toggling.
    for (k = 0; k < 16; k++)
    begin
      ctrl = {1'h1, k[2:0], k[0], ~k[3], 2'h3};
      target <= 8'h1B * k[7:0] + 8'h0D;
      expPos = 8'h01 << {k[1:0], k[2]};
      expNeg = k[3] ? 8'h01 << {k[1:0], ~k[2]} : 8'h00;
      host_link_inst.selectLink(1'h0);
      if (k == 0)
      begin
        host_link_inst.clockBits(5, 32'h16);
        host_link_inst.selectLink(1'h1);
        repeat (4) @(posedge clock);
        host_link_inst.selectLink(1'h0);
      end
      host_link_inst.clockBits(10, {24'h0, ctrl});
      check("pos route", {24'h0, posInput}, {24'h0, expPos});
      check("neg route", {23'h0, commonReturn, negInput}, {23'h0, ~k[3], expNeg});
      check("unipolar", {31'h0, unipolarMode}, {31'h0, k[0]});
      host_link_inst.clockBits(18, 32'h0);
      if (k == 0)
        check("track window", host_link_inst.thBits & 32'hFFFFFFF, 32'hC0000);
      check("strobe pulse", host_link_inst.stbBits & 32'hFFFF, 32'h300);
      check("result bits", host_link_inst.rxBits & 32'hFF, {24'h0, target});
      host_link_inst.selectLink(1'h1);
      repeat (6) @(posedge clock);
      check("ext release", {30'h0, serialOutEn, conversionStrobeEn}, 32'h0);
      axiRead(`OFF_STATUS);
      check("status", rd & 32'h1FFF, 32'h1200 | {24'h0, target});
      axiRead(`OFF_CONFIG);
      check("config", rd, {24'h0, ctrl});
    end
    ctrl = 8'hFC;
    target <= 8'h3C;
    host_link_inst.selectLink(1'h0);
    host_link_inst.clockBits(10, {24'h0, ctrl});
    repeat (6) @(posedge clock);
    check("strobe busy", {31'h0, strobeWire}, 32'h0);
    for (w = 0; w < 400 && strobeWire !== 1'h1; w++)
      @(posedge clock);
    if (w == 400)
      giveUp();
    host_link_inst.clockBits(9, 32'h0);
    check("internal result", host_link_inst.rxBits & 32'hFF, {24'h0, target});
    check("soft power down", {31'h0, powerDown}, 32'h1);
    host_link_inst.selectLink(1'h1);
    repeat (6) @(posedge clock);
    check("strobe driven", {31'h0, conversionStrobeEn}, 32'h1);
    testDone();
  end
endmodule // tb_top
